/* mip_pkg.sv */
// Constants and types shared by the interrupt priority and standby unit
package mip_pkg;

    // Vector table geometry
    localparam int VEC_COUNT = 10;
    localparam int VEC_ADDR_W = 17;
    localparam logic [16:0] VEC_BASE_ADDR = 17'h0_0003;
    localparam logic [16:0] VEC_STRIDE = 17'h0_0008;
    localparam logic [16:0] VEC_LAST_ADDR = 17'h0_004B;

    // Vector indices (0 based, vector number minus one)
    localparam int VEC_EXT_ZERO = 0;
    localparam int VEC_EXT_ONE = 1;
    localparam int VEC_SHARED_A = 2;
    localparam int VEC_SHARED_B = 3;
    localparam int VEC_TIMER_HIGH = 4;
    localparam int VEC_TIMER_ONE = 5;
    localparam int VEC_SERIAL_RX = 6;
    localparam int VEC_SERIAL_TX = 7;
    localparam int VEC_CONVERTER = 8;
    localparam int VEC_PORT_ZERO = 9;

    // Vectors that may take the highest level
    localparam int VEC_TOP_CAPABLE = 2;

    // Request source count
    localparam int SRC_COUNT = 32;

    // External pin inputs
    localparam int EXT_COUNT = 8;

    // Reset values
    localparam logic [16:0] VEC_ADDR_RESET = 17'h0_0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [7:0] EXT_SYNC_RESET = 8'h00;

    // Priority levels, ordered so a larger code outranks a smaller one
    typedef enum logic [1:0] {
        MIP_LVL_NONE = 2'h0,
        MIP_LVL_LOW = 2'h1,
        MIP_LVL_HIGH = 2'h2,
        MIP_LVL_TOP = 2'h3
    } mip_level_e;

    // Standby modes
    typedef enum logic [1:0] {
        MIP_RUN,
        MIP_HALT,
        MIP_HOLD,
        MIP_XHOLD
    } mip_mode_e;

endpackage

/* mip_interrupt_unit.sv */
// Interrupt priority, vectoring and standby wake unit
//
// What this block does
// - Three levels ranked top over high over low decide every arbitration.
// - Only vectors 00003H and 0000BH may be top level; others high or low.
// - A request at or below the level in service is not accepted.
// - Among pending vectors the highest level wins.
// - Equal levels: the smallest vector address wins.
// - Sources merge onto ten vectors from 00003H, eight bytes apart, to 0004BH.
// - Vector 00013H: external two, four, timer zero low, timer A low, infrared.
// - Vector 0001BH: external three, five and both base timer sources.
// - Vector 00023H: timer zero high, external six, timer A high.
// - Vector 0002BH: timer one low and high, external seven, two-wire serial.
// - Vector 00033H: synchronous serial A and both asynchronous receive events.
// - Vector 0003BH: serial B and both asynchronous transmit events.
// - 00043H: converter, timers six, seven; 0004BH: port 0, timers four, five, pulse width.
// - Halt ends on system reset or any accepted interrupt.
// - Stop ends on reset pin low or external 0,1,2,4,5 at set level.
// - A port 0 interrupt source also ends either stop state.
// - Crystal stop also ends on base timer or infrared receiver interrupt.
`timescale 1ns/1ps

module mip_interrupt_unit (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Reset pin, active low, asynchronous to the clock
    input wire logic rst_pin_n_in,
    // External interrupt pins and their active level (1 = high)
    input wire logic [7:0] ext_irq_in,
    input wire logic [7:0] ext_active_high_in,
    // Peripheral request flags, same clock
    input wire logic timer_zero_low_evt_in,
    input wire logic timer_zero_high_evt_in,
    input wire logic timer_a_low_evt_in,
    input wire logic timer_a_high_evt_in,
    input wire logic infrared_rx_evt_in,
    input wire logic base_timer_zero_evt_in,
    input wire logic base_timer_one_evt_in,
    input wire logic timer_one_low_evt_in,
    input wire logic timer_one_high_evt_in,
    input wire logic twowire_master_serial_in,
    input wire logic sync_serial_a_in,
    input wire logic uart_one_rx_in,
    input wire logic uart_two_rx_in,
    input wire logic sync_async_serial_b_in,
    input wire logic uart_one_tx_in,
    input wire logic uart_two_tx_in,
    input wire logic converter_evt_in,
    input wire logic timer_six_evt_in,
    input wire logic timer_seven_evt_in,
    input wire logic port_zero_evt_in,
    input wire logic timer_four_evt_in,
    input wire logic timer_five_evt_in,
    input wire logic pwm_pair_evt_in,
    input wire logic remote_pulse_width_evt_in,
    // Per-vector configuration
    input wire logic [9:0] vec_enable_in,
    input wire logic [9:0] vec_level_up_in,
    // Core sequencer side
    input wire logic [1:0] svc_level_in,
    input wire logic halt_enter_in,
    input wire logic hold_enter_in,
    input wire logic xhold_enter_in,
    // Request to the core
    output logic req_valid_out,
    output logic [16:0] req_vector_out,
    output logic [1:0] req_level_out,
    // Standby state to the core and clock control
    output logic halt_out,
    output logic hold_out,
    output logic xhold_out,
    output logic wake_out
);

    // Address of a vector by index
    function automatic logic [16:0] vec_addr(input logic [3:0] idx);
        logic [16:0] off;
        off = {13'h0_000, idx} << 3;
        return mip_pkg::VEC_BASE_ADDR + off;
    endfunction

    // Level configured for a vector; only the first two may reach top
    function automatic logic [1:0] vec_level(input int idx, input logic up);
        logic [1:0] lvl;
        lvl = mip_pkg::MIP_LVL_LOW;
        if (up && idx < mip_pkg::VEC_TOP_CAPABLE) begin
            lvl = mip_pkg::MIP_LVL_TOP;
        end else if (up) begin
            lvl = mip_pkg::MIP_LVL_HIGH;
        end
        return lvl;
    endfunction

    // Pin synchronisers
    logic [7:0] ext_meta;
    logic [7:0] ext_sync;
    logic rst_pin_meta;
    logic rst_pin_sync_n;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_meta <= mip_pkg::EXT_SYNC_RESET;
            ext_sync <= mip_pkg::EXT_SYNC_RESET;
        end else begin
            ext_meta <= ext_irq_in;
            ext_sync <= ext_meta;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_pin_meta <= 1'b1;
            rst_pin_sync_n <= 1'b1;
        end else begin
            rst_pin_meta <= rst_pin_n_in;
            rst_pin_sync_n <= rst_pin_meta;
        end
    end

    // Masks pins until both stages hold pin values; reset zeros look like active-low requests
    logic [1:0] sync_fill;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_fill <= mip_pkg::SYNC_RESET;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    // External pin at its configured level
    logic [7:0] ext_act;
    assign ext_act = (ext_sync ~^ ext_active_high_in)
        & {8{sync_fill[1]}};

    // Sources merged onto vectors
    logic [9:0] vec_raw;
    always_comb begin
        vec_raw = 10'h000;
        vec_raw[mip_pkg::VEC_EXT_ZERO] = ext_act[0];
        vec_raw[mip_pkg::VEC_EXT_ONE] = ext_act[1];
        vec_raw[mip_pkg::VEC_SHARED_A] = ext_act[2] | ext_act[4] | timer_zero_low_evt_in
            | timer_a_low_evt_in | infrared_rx_evt_in;
        vec_raw[mip_pkg::VEC_SHARED_B] = ext_act[3] | ext_act[5] | base_timer_zero_evt_in
            | base_timer_one_evt_in;
        vec_raw[mip_pkg::VEC_TIMER_HIGH] = timer_zero_high_evt_in | ext_act[6]
            | timer_a_high_evt_in;
        vec_raw[mip_pkg::VEC_TIMER_ONE] = timer_one_low_evt_in | timer_one_high_evt_in
            | ext_act[7] | twowire_master_serial_in;
        vec_raw[mip_pkg::VEC_SERIAL_RX] = sync_serial_a_in | uart_one_rx_in
            | uart_two_rx_in;
        vec_raw[mip_pkg::VEC_SERIAL_TX] = sync_async_serial_b_in | uart_one_tx_in
            | uart_two_tx_in;
        vec_raw[mip_pkg::VEC_CONVERTER] = converter_evt_in | timer_six_evt_in
            | timer_seven_evt_in;
        vec_raw[mip_pkg::VEC_PORT_ZERO] = port_zero_evt_in | timer_four_evt_in
            | timer_five_evt_in | pwm_pair_evt_in | remote_pulse_width_evt_in;
    end

    logic [9:0] vec_pend;
    assign vec_pend = vec_raw & vec_enable_in;

    // Arbitration: strictly greater keeps the earlier, smaller address on a tie
    logic [1:0] win_level;
    logic [3:0] win_idx;
    always_comb begin
        logic [1:0] lvl;
        lvl = mip_pkg::MIP_LVL_NONE;
        win_level = mip_pkg::MIP_LVL_NONE;
        win_idx = 4'h0;
        for (int v = 0; v < mip_pkg::VEC_COUNT; v++) begin
            lvl = vec_level(v, vec_level_up_in[v]);
            if (vec_pend[v] && lvl > win_level) begin
                win_level = lvl;
                win_idx = 4'(v);
            end
        end
    end

    // Winner must outrank the level in service
    logic accept;
    assign accept = win_level > svc_level_in;

    // Request outputs to the core
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_valid_out <= 1'b0;
            req_vector_out <= mip_pkg::VEC_ADDR_RESET;
            req_level_out <= mip_pkg::MIP_LVL_NONE;
        end else begin
            req_valid_out <= accept;
            req_vector_out <= accept ? vec_addr(win_idx) : mip_pkg::VEC_ADDR_RESET;
            req_level_out <= accept ? win_level : mip_pkg::MIP_LVL_NONE;
        end
    end

    // Standby wake conditions
    logic stop_wake;
    logic xstop_wake;
    assign stop_wake = !rst_pin_sync_n | ext_act[0] | ext_act[1] | ext_act[2]
        | ext_act[4] | ext_act[5] | port_zero_evt_in;
    assign xstop_wake = stop_wake | base_timer_zero_evt_in | base_timer_one_evt_in
        | infrared_rx_evt_in;

    mip_pkg::mip_mode_e mode;
    mip_pkg::mip_mode_e next_mode;
    logic next_wake;

    always_comb begin
        next_mode = mode;
        next_wake = 1'b0;
        unique case (mode)
            mip_pkg::MIP_RUN: begin
                if (xhold_enter_in) begin
                    next_mode = mip_pkg::MIP_XHOLD;
                end else if (hold_enter_in) begin
                    next_mode = mip_pkg::MIP_HOLD;
                end else if (halt_enter_in) begin
                    next_mode = mip_pkg::MIP_HALT;
                end
            end
            mip_pkg::MIP_HALT: begin
                if (accept || !rst_pin_sync_n) begin
                    next_mode = mip_pkg::MIP_RUN;
                    next_wake = 1'b1;
                end
            end
            mip_pkg::MIP_HOLD: begin
                if (stop_wake) begin
                    next_mode = mip_pkg::MIP_RUN;
                    next_wake = 1'b1;
                end
            end
            mip_pkg::MIP_XHOLD: begin
                if (xstop_wake) begin
                    next_mode = mip_pkg::MIP_RUN;
                    next_wake = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode <= mip_pkg::MIP_RUN;
            wake_out <= 1'b0;
            halt_out <= 1'b0;
            hold_out <= 1'b0;
            xhold_out <= 1'b0;
        end else begin
            mode <= next_mode;
            wake_out <= next_wake;
            halt_out <= next_mode == mip_pkg::MIP_HALT;
            hold_out <= next_mode == mip_pkg::MIP_HOLD;
            xhold_out <= next_mode == mip_pkg::MIP_XHOLD;
        end
    end

    // Checking helpers: a rival that should have beaten the presented winner
    logic rival_seen;
    always_comb begin
        logic [1:0] lvl;
        lvl = mip_pkg::MIP_LVL_NONE;
        rival_seen = 1'b0;
        for (int v = 0; v < mip_pkg::VEC_COUNT; v++) begin
            lvl = vec_level(v, vec_level_up_in[v]);
            if (vec_pend[v] && (lvl > win_level || (lvl == win_level && 4'(v) < win_idx))) begin
                rival_seen = 1'b1;
            end
        end
    end

    a_no_low_accept: assert property (@(posedge clk_in) disable iff (rst_in)
        req_valid_out |-> req_level_out > $past(svc_level_in))
        else $error("request presented at or below the level in service");

    a_accept_shown: assert property (@(posedge clk_in) disable iff (rst_in)
        (win_level > svc_level_in) |=> req_valid_out && req_level_out == $past(win_level))
        else $error("accepted winner not presented to the core");

    a_vector_grid: assert property (@(posedge clk_in) disable iff (rst_in)
        req_valid_out |-> req_vector_out >= mip_pkg::VEC_BASE_ADDR
            && req_vector_out <= mip_pkg::VEC_LAST_ADDR && req_vector_out[2:0] == 3'h3)
        else $error("vector address off the table");

    a_top_limited: assert property (@(posedge clk_in) disable iff (rst_in)
        req_valid_out && req_level_out == mip_pkg::MIP_LVL_TOP
            |-> req_vector_out <= 17'h0_000B)
        else $error("top level given to a vector that may not hold it");

    a_best_winner: assert property (@(posedge clk_in) disable iff (rst_in)
        win_level != mip_pkg::MIP_LVL_NONE |-> !rival_seen)
        else $error("a higher or smaller pending vector was passed over");

    a_share_infrared: assert property (@(posedge clk_in) disable iff (rst_in)
        infrared_rx_evt_in && vec_enable_in[mip_pkg::VEC_SHARED_A] |-> vec_pend[2])
        else $error("infrared receiver not routed to the third vector");

    a_share_base: assert property (@(posedge clk_in) disable iff (rst_in)
        base_timer_one_evt_in && vec_enable_in[mip_pkg::VEC_SHARED_B] |-> vec_pend[3])
        else $error("base timer not routed to the fourth vector");

    a_route_rest: assert property (@(posedge clk_in) disable iff (rst_in)
        (timer_a_high_evt_in && vec_enable_in[4] |-> vec_pend[4])
            and (twowire_master_serial_in && vec_enable_in[5] |-> vec_pend[5]))
        else $error("timer or two-wire source misrouted");

    a_route_serial: assert property (@(posedge clk_in) disable iff (rst_in)
        (uart_two_rx_in && vec_enable_in[6] |-> vec_pend[6])
            and (uart_two_tx_in && vec_enable_in[7] |-> vec_pend[7]))
        else $error("serial source misrouted");

    a_route_last: assert property (@(posedge clk_in) disable iff (rst_in)
        (timer_seven_evt_in && vec_enable_in[8] |-> vec_pend[8])
            and (remote_pulse_width_evt_in && vec_enable_in[9] |-> vec_pend[9]))
        else $error("converter or port vector source misrouted");

    a_halt_wakes: assert property (@(posedge clk_in) disable iff (rst_in)
        mode == mip_pkg::MIP_HALT && accept |=> !halt_out && wake_out ##1 !wake_out)
        else $error("halt not ended by an accepted interrupt");

    a_hold_wakes: assert property (@(posedge clk_in) disable iff (rst_in)
        mode == mip_pkg::MIP_HOLD && (ext_act[5] || port_zero_evt_in) |=> mode == mip_pkg::MIP_RUN)
        else $error("stop not ended by a pin or port 0 source");

    a_hold_stays: assert property (@(posedge clk_in) disable iff (rst_in)
        mode == mip_pkg::MIP_HOLD && !stop_wake |=> hold_out && !wake_out)
        else $error("stop ended without a wake source");

    a_xhold_wakes: assert property (@(posedge clk_in) disable iff (rst_in)
        mode == mip_pkg::MIP_XHOLD && (base_timer_zero_evt_in || infrared_rx_evt_in)
            |=> !xhold_out && wake_out)
        else $error("crystal stop not ended by base timer or infrared source");

    a_refused_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        (win_level <= svc_level_in) |=> !req_valid_out && req_vector_out == 17'h0_0000)
        else $error("refused winner still presented to the core");

    a_wake_single: assert property (@(posedge clk_in) disable iff (rst_in)
        wake_out |=> !wake_out)
        else $error("wake pulse longer than one cycle");

    a_mode_single: assert property (@(posedge clk_in) disable iff (rst_in)
        $onehot0({halt_out, hold_out, xhold_out}))
        else $error("more than one standby mode shown at once");

endmodule // mip_interrupt_unit

/* mip_core_model.sv */
// Behavioural core sequencer that takes presented interrupts and reports its level
`timescale 1ns/1ps

module mip_core_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Request from the unit
    input wire logic req_valid_in,
    input wire logic [1:0] req_level_in,
    // Bench control: take, take one cycle late, return from service
    input wire logic take_in,
    input wire logic slow_in,
    input wire logic ret_in,
    // Level now in service
    output logic [1:0] svc_level_out
);
    logic armed;

    // A slow take needs the request seen on two edges in a row
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            svc_level_out <= 2'h0;
            armed <= 1'b0;
        end else if (ret_in) begin
            svc_level_out <= 2'h0;
            armed <= 1'b0;
        end else if (take_in && req_valid_in && (armed || !slow_in)) begin
            svc_level_out <= req_level_in;
            armed <= 1'b0;
        end else begin
            armed <= take_in && slow_in && req_valid_in;
        end
    end
endmodule // mip_core_model

/* tb_mip_interrupt_unit.sv */
// Self-checking testbench of the interrupt priority and standby unit
`timescale 1ns/1ps

module tb_mip_interrupt_unit;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic rst_pin_n = 1'b1;
    logic [7:0] ext_irq = 8'hA5;
    logic [23:0] src = 24'h00_0000;
    logic [9:0] vec_en = 10'h3FF;
    logic [9:0] lvl_up = 10'h000;
    logic halt_en = 1'b0;
    logic hold_en = 1'b0;
    logic xhold_en = 1'b0;
    logic take = 1'b0;
    logic slow = 1'b0;
    logic ret = 1'b0;
    logic [1:0] svc;
    logic req_valid;
    logic [16:0] req_vec;
    logic [1:0] req_lvl;
    logic halt;
    logic hold;
    logic xhold;
    logic wake;
    logic [19:0] got;
    logic [19:0] modes;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int src_vec [24] = '{2, 4, 2, 4, 2, 3, 3, 5, 5, 5, 6, 6, 6, 7, 7, 7, 8, 8, 8, 9, 9, 9, 9, 9};
    int ext_vec [8] = '{0, 1, 2, 3, 2, 3, 4, 5};

    assign got = {req_vec, req_lvl, req_valid};
    assign modes = {16'h0000, halt, hold, xhold, wake};

    mip_interrupt_unit i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .rst_pin_n_in(rst_pin_n),
        .ext_irq_in(ext_irq), .ext_active_high_in(8'h5A),
        .timer_zero_low_evt_in(src[0]), .timer_zero_high_evt_in(src[1]),
        .timer_a_low_evt_in(src[2]), .timer_a_high_evt_in(src[3]),
        .infrared_rx_evt_in(src[4]), .base_timer_zero_evt_in(src[5]),
        .base_timer_one_evt_in(src[6]), .timer_one_low_evt_in(src[7]),
        .timer_one_high_evt_in(src[8]), .twowire_master_serial_in(src[9]),
        .sync_serial_a_in(src[10]), .uart_one_rx_in(src[11]), .uart_two_rx_in(src[12]),
        .sync_async_serial_b_in(src[13]), .uart_one_tx_in(src[14]), .uart_two_tx_in(src[15]),
        .converter_evt_in(src[16]), .timer_six_evt_in(src[17]), .timer_seven_evt_in(src[18]),
        .port_zero_evt_in(src[19]), .timer_four_evt_in(src[20]), .timer_five_evt_in(src[21]),
        .pwm_pair_evt_in(src[22]), .remote_pulse_width_evt_in(src[23]),
        .vec_enable_in(vec_en), .vec_level_up_in(lvl_up), .svc_level_in(svc),
        .halt_enter_in(halt_en), .hold_enter_in(hold_en), .xhold_enter_in(xhold_en),
        .req_valid_out(req_valid), .req_vector_out(req_vec), .req_level_out(req_lvl),
        .halt_out(halt), .hold_out(hold), .xhold_out(xhold), .wake_out(wake)
    );

    mip_core_model i_core (
        .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid), .req_level_in(req_lvl),
        .take_in(take), .slow_in(slow), .ret_in(ret), .svc_level_out(svc)
    );

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic finish_test();
        $display("Compared %0d samples, %0d mismatches", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Expected request word for vector index v at level l
    function automatic logic [19:0] ex(input int v, input logic [1:0] l);
        logic [16:0] a;
        a = mip_pkg::VEC_BASE_ADDR + mip_pkg::VEC_STRIDE * 17'(v);
        return {a, l, 1'b1};
    endfunction

    task automatic wait_wake();
        int n;
        n = 0;
        while (wake !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        chk(modes, 20'h0_0001);
    endtask

    task automatic enter(input logic x);
        @(posedge clk_in);
        xhold_en <= x;
        hold_en <= !x;
        @(posedge clk_in);
        xhold_en <= 1'b0;
        hold_en <= 1'b0;
        tick(1);
        chk(modes, x ? 20'h0_0002 : 20'h0_0004);
    endtask

    task automatic t_map();
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_in);
            src <= 24'h00_0001 << i;
            tick(1);
            chk(got, ex(src_vec[i], 2'h1));
        end
        @(posedge clk_in);
        src <= 24'h00_0000;
        tick(1);
        chk(got, 20'h0_0000);
    endtask

    task automatic t_ext();
        @(posedge clk_in);
        lvl_up <= 10'h3FF;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            ext_irq <= 8'hA5 ^ (8'h01 << i);
            tick(3);
            chk(got, ex(ext_vec[i], (i < 2) ? 2'h3 : 2'h2));
        end
        @(posedge clk_in);
        ext_irq <= 8'hA5;
        tick(3);
        chk(got, 20'h0_0000);
    endtask

    task automatic t_prio();
        @(posedge clk_in);
        lvl_up <= 10'h100;
        src <= 24'h0A_0001;
        tick(1);
        chk(got, ex(8, 2'h2));
        @(posedge clk_in);
        lvl_up <= 10'h000;
        tick(1);
        chk(got, ex(2, 2'h1));
        @(posedge clk_in);
        vec_en <= 10'h3FB;
        tick(1);
        chk(got, ex(8, 2'h1));
        @(posedge clk_in);
        vec_en <= 10'h3FF;
        src <= 24'h00_0000;
    endtask

    task automatic t_refuse();
        @(posedge clk_in);
        lvl_up <= 10'h105;
        src <= 24'h02_0000;
        take <= 1'b1;
        slow <= 1'b1;
        tick(4);
        chk({18'h0_0000, svc}, 20'h0_0002);
        chk(got, 20'h0_0000);
        @(posedge clk_in);
        take <= 1'b0;
        src <= 24'h02_0001;
        tick(2);
        chk(got, 20'h0_0000);
        @(posedge clk_in);
        ext_irq <= 8'hA4;
        tick(3);
        chk(got, ex(0, 2'h3));
        @(posedge clk_in);
        ext_irq <= 8'hA5;
        src <= 24'h00_0000;
        ret <= 1'b1;
        @(posedge clk_in);
        ret <= 1'b0;
        tick(3);
    endtask

    task automatic t_halt();
        @(posedge clk_in);
        halt_en <= 1'b1;
        @(posedge clk_in);
        halt_en <= 1'b0;
        hold_en <= 1'b1;
        @(posedge clk_in);
        hold_en <= 1'b0;
        tick(3);
        chk(modes, 20'h0_0008);
        @(posedge clk_in);
        src <= 24'h00_0008;
        wait_wake();
        @(posedge clk_in);
        src <= 24'h00_0000;
    endtask

    task automatic t_stop();
        int pins [5] = '{0, 1, 2, 4, 5};
        foreach (pins[k]) begin
            enter(1'b0);
            @(posedge clk_in);
            ext_irq <= 8'hA5 ^ (8'h01 << pins[k]);
            wait_wake();
            @(posedge clk_in);
            ext_irq <= 8'hA5;
            tick(4);
        end
        enter(1'b0);
        @(posedge clk_in);
        src <= 24'h00_0070;
        tick(4);
        chk(modes, 20'h0_0004);
        @(posedge clk_in);
        src <= 24'h08_0000;
        wait_wake();
        @(posedge clk_in);
        src <= 24'h00_0000;
        enter(1'b1);
        @(posedge clk_in);
        src <= 24'h00_0040;
        wait_wake();
        @(posedge clk_in);
        src <= 24'h00_0000;
        enter(1'b1);
        @(posedge clk_in);
        src <= 24'h00_0010;
        wait_wake();
        @(posedge clk_in);
        src <= 24'h00_0000;
        enter(1'b0);
        @(posedge clk_in);
        rst_pin_n <= 1'b0;
        wait_wake();
        @(posedge clk_in);
        rst_pin_n <= 1'b1;
        tick(4);
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        tick(1);
        chk(got | modes, 20'h0_0000);
        t_map();
        t_ext();
        t_prio();
        t_refuse();
        t_halt();
        t_stop();
        finish_test();
    end
endmodule // tb_mip_interrupt_unit
